// File: hdl/brag_addr_gen.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - pointer select 15 never bit-reverses
// - reverse_enable bit 15 must be set
// - only indirect pre- or post-increment
// - 15-bit pivot_modifier in bits 14:0
// - word data, pivot scaled to bytes
// - byte or other modes get normal addresses
// - pointer plus pivot, mode increment ignored
// - effective address lsb forced zero
// - bit reversal beats write-unit modulo
// - read unit keeps modulo correction
// - reversal only on write address path
// - pointer and modifier both bit-reversed, added, sum reversed back
module brag_addr_gen
  import brag_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire brag_req_t   wr_req_i,
  input  wire brag_req_t   rd_req_i,
  output brag_rsp_t        wr_rsp_o,
  output brag_rsp_t        rd_rsp_o
);

  logic [15:0] modctl_r;
  logic [15:0] revctl_r;
  logic [15:0] modlo_r;
  logic [15:0] modhi_r;
  logic [15:0] last_ea_r;
  logic        last_brev_r;
  logic        last_mod_r;
  logic        dph_wr_r;
  logic        dph_rd_r;
  logic [31:0] dph_addr_r;
  logic        rev_active;
  logic [15:0] rev_sum;
  logic [15:0] pivot_bytes;
  brag_rsp_t   wr_rsp_nxt;
  brag_rsp_t   rd_rsp_nxt;

  function automatic logic [15:0] brag_wrap(
    input logic [15:0] a,
    input logic        up,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] span;
    span = hi - lo + BRAG_BYTE_STEP;
    if (up && (a > hi)) begin
      brag_wrap = a - span;
    end else if (!up && (a < lo)) begin
      brag_wrap = a + span;
    end else begin
      brag_wrap = a;
    end
  endfunction

  // shared by both address units; only the write unit passes brev
  function automatic brag_rsp_t brag_gen(
    input brag_req_t   q,
    input logic        mod_on,
    input logic [3:0]  mod_sel,
    input logic [15:0] lo,
    input logic [15:0] hi,
    input logic        brev,
    input logic [15:0] rsum
  );
    brag_rsp_t   r;
    logic [15:0] step;
    logic [15:0] nxt;
    logic [15:0] fixed;
    logic        pre;
    logic        up;
    logic        fix;
    logic        wb;
    r     = '0;
    step  = q.is_byte ? BRAG_BYTE_STEP : BRAG_WORD_STEP;
    nxt   = q.ptr_val;
    pre   = 1'b0;
    up    = 1'b1;
    wb    = 1'b0;
    fix   = mod_on && (q.ptr_sel == mod_sel) && !brev;
    unique case (q.mode)
      BRAG_POST_INC: begin
        nxt = q.ptr_val + step;
        wb  = 1'b1;
      end
      BRAG_PRE_INC: begin
        nxt = q.ptr_val + step;
        pre = 1'b1;
        wb  = 1'b1;
      end
      BRAG_POST_DEC: begin
        nxt = q.ptr_val - step;
        up  = 1'b0;
        wb  = 1'b1;
      end
      BRAG_PRE_DEC: begin
        nxt = q.ptr_val - step;
        pre = 1'b1;
        up  = 1'b0;
        wb  = 1'b1;
      end
      BRAG_OFFSET: begin
        nxt = q.ptr_val + q.offset;
        pre = 1'b1;
        up  = !q.offset[15];
      end
      default: begin
        fix = 1'b0;
      end
    endcase
    fixed = fix ? brag_wrap(nxt, up, lo, hi) : nxt;
    r.modfix = q.valid && fix && (fixed != nxt);
    nxt = fixed;
    if (brev) begin
      // mode increment is dropped, the pivot sum replaces it
      nxt = {rsum[15:1], 1'b0};
    end
    r.valid  = q.valid;
    r.ea     = pre ? nxt : q.ptr_val;
    if (brev) begin
      r.ea[0] = 1'b0;
    end
    r.wb_en  = q.valid && wb;
    r.wb_sel = q.ptr_sel;
    r.wb_val = nxt;
    r.bitrev = q.valid && brev;
    return r;
  endfunction

  // ---------------- address generation ----------------

  // pivot counts words, so it is doubled into a byte modifier
  assign pivot_bytes = {revctl_r[BRAG_PIVOT_HI:BRAG_PIVOT_LO], 1'b0};

  brag_rev_adder u_rev (
    .ptr      (wr_req_i.ptr_val),
    .modifier (pivot_bytes),
    .sum      (rev_sum)
  );

  always_comb begin
    rev_active = wr_req_i.valid
              && revctl_r[BRAG_REV_EN_BIT]
              && (modctl_r[BRAG_REV_SEL_HI:BRAG_REV_SEL_LO] != BRAG_STACK_PTR)
              && (wr_req_i.ptr_sel == modctl_r[BRAG_REV_SEL_HI:BRAG_REV_SEL_LO])
              && ((wr_req_i.mode == BRAG_PRE_INC) || (wr_req_i.mode == BRAG_POST_INC))
              && !wr_req_i.is_byte;
  end

  always_comb begin
    wr_rsp_nxt = brag_gen(wr_req_i, modctl_r[BRAG_WR_MOD_EN_BIT],
                          modctl_r[BRAG_WR_SEL_HI:BRAG_WR_SEL_LO], modlo_r, modhi_r,
                          rev_active, rev_sum);
    // read unit never reverses and keeps its modulo wrap
    rd_rsp_nxt = brag_gen(rd_req_i, modctl_r[BRAG_RD_MOD_EN_BIT],
                          modctl_r[BRAG_RD_SEL_HI:BRAG_RD_SEL_LO], modlo_r, modhi_r,
                          1'b0, 16'h0000);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_rsp_o <= '0;
      rd_rsp_o <= '0;
    end else begin
      wr_rsp_o <= wr_rsp_nxt;
      rd_rsp_o <= rd_rsp_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_ea_r   <= 16'h0000;
      last_brev_r <= 1'b0;
      last_mod_r  <= 1'b0;
    end else if (wr_rsp_nxt.valid) begin
      last_ea_r   <= wr_rsp_nxt.ea;
      last_brev_r <= wr_rsp_nxt.bitrev;
      last_mod_r  <= wr_rsp_nxt.modfix;
    end
  end

  // ---------------- AHB-Lite slave ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r   <= 1'b0;
      dph_rd_r   <= 1'b0;
      dph_addr_r <= 32'h0000_0000;
    end else begin
      dph_rd_r <= 1'b0;
      if (hready) begin
        dph_wr_r <= hsel && htrans[1] && hwrite;
        dph_rd_r <= hsel && htrans[1] && !hwrite;
        if (hsel && htrans[1]) begin
          dph_addr_r <= haddr & BRAG_ADDR_MASK;
        end
      end
    end
  end

  // one wait state on reads so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (dph_rd_r) begin
      unique case (dph_addr_r)
        BRAG_MODCTL_OFS: hrdata <= {16'h0000, modctl_r};
        BRAG_REVCTL_OFS: hrdata <= {16'h0000, revctl_r};
        BRAG_MODLO_OFS:  hrdata <= {16'h0000, modlo_r};
        BRAG_MODHI_OFS:  hrdata <= {16'h0000, modhi_r};
        BRAG_STATUS_OFS: hrdata <= {14'h0000, last_mod_r, last_brev_r, last_ea_r};
        default:         hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // new control takes effect on the cycle after the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modctl_r <= BRAG_MODCTL_RST;
      revctl_r <= BRAG_REVCTL_RST;
      modlo_r  <= BRAG_MODLO_RST;
      modhi_r  <= BRAG_MODHI_RST;
    end else if (dph_wr_r) begin
      unique case (dph_addr_r)
        BRAG_MODCTL_OFS: modctl_r <= hwdata[15:0];
        BRAG_REVCTL_OFS: revctl_r <= hwdata[15:0];
        BRAG_MODLO_OFS:  modlo_r  <= hwdata[15:0];
        BRAG_MODHI_OFS:  modhi_r  <= hwdata[15:0];
        default:         modctl_r <= modctl_r;
      endcase
    end
  end

  // ---------------- assertions ----------------

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_no_stack;
    wr_rsp_o.bitrev |-> ($past(modctl_r[BRAG_REV_SEL_HI:BRAG_REV_SEL_LO]) != BRAG_STACK_PTR)
                     && ($past(wr_req_i.ptr_sel) != BRAG_STACK_PTR);
  endproperty
  a_no_stack: assert property (p_no_stack) else $error("bit reversal on stack pointer");

  property p_needs_enable;
    !$past(revctl_r[BRAG_REV_EN_BIT]) |-> !wr_rsp_o.bitrev;
  endproperty
  a_needs_enable: assert property (p_needs_enable) else $error("bit reversal while disabled");

  property p_mode_word;
    wr_rsp_o.bitrev |-> !$past(wr_req_i.is_byte)
                     && (($past(wr_req_i.mode) == BRAG_PRE_INC) || ($past(wr_req_i.mode) == BRAG_POST_INC));
  endproperty
  a_mode_word: assert property (p_mode_word) else $error("bit reversal in wrong mode or size");

  property p_lsb_clear;
    wr_rsp_o.bitrev |-> (wr_rsp_o.ea[0] == 1'b0) && (wr_rsp_o.wb_val[0] == 1'b0);
  endproperty
  a_lsb_clear: assert property (p_lsb_clear) else $error("bit-reversed address lsb set");

  property p_priority;
    wr_rsp_o.bitrev |-> !wr_rsp_o.modfix;
  endproperty
  a_priority: assert property (p_priority) else $error("modulo applied during bit reversal");

  property p_rd_modulo;
    rd_req_i.valid && modctl_r[BRAG_RD_MOD_EN_BIT] && !rd_req_i.is_byte
      && (rd_req_i.ptr_sel == modctl_r[BRAG_RD_SEL_HI:BRAG_RD_SEL_LO])
      && (rd_req_i.mode == BRAG_POST_INC) && ((rd_req_i.ptr_val + BRAG_BYTE_STEP) == modhi_r)
      && (modhi_r >= modlo_r) && (modhi_r < 16'hFFFE)
      |=> rd_rsp_o.modfix && (rd_rsp_o.wb_val == $past(modlo_r));
  endproperty
  a_rd_modulo: assert property (p_rd_modulo) else $error("read unit lost modulo wrap");

  property p_rd_no_rev;
    !rd_rsp_o.bitrev;
  endproperty
  a_rd_no_rev: assert property (p_rd_no_rev) else $error("bit reversal on read path");

  property p_writeback;
    wr_rsp_o.bitrev |-> wr_rsp_o.wb_en && (wr_rsp_o.wb_sel == $past(wr_req_i.ptr_sel))
      && (($past(wr_req_i.mode) == BRAG_PRE_INC) ? (wr_rsp_o.ea == wr_rsp_o.wb_val)
                                                  : (wr_rsp_o.ea == {$past(wr_req_i.ptr_val[15:1]), 1'b0}));
  endproperty
  a_writeback: assert property (p_writeback) else $error("bit-reversed writeback wrong");

  property p_no_incr;
    wr_rsp_o.bitrev && ($past(revctl_r[BRAG_PIVOT_HI:BRAG_PIVOT_LO]) == 15'h0000)
      |-> wr_rsp_o.wb_val == {$past(wr_req_i.ptr_val[15:1]), 1'b0};
  endproperty
  a_no_incr: assert property (p_no_incr) else $error("mode increment applied in bit reversal");

  property p_rev_carry;
    wr_rsp_o.bitrev && ($past(wr_req_i.ptr_val[0]) == 1'b0)
      && ($past(revctl_r[BRAG_PIVOT_HI:BRAG_PIVOT_LO]) == 15'h0004)
      && ($past(wr_req_i.ptr_val[3]) == 1'b1)
      |-> (wr_rsp_o.wb_val[3] == 1'b0) && (wr_rsp_o.wb_val[2] == ~$past(wr_req_i.ptr_val[2]));
  endproperty
  a_rev_carry: assert property (p_rev_carry) else $error("reverse carry wrong");

  property p_rd_wait;
    hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  c_brev_pre:  cover property (wr_rsp_o.bitrev && $past(wr_req_i.mode) == BRAG_PRE_INC);
  c_brev_post: cover property (wr_rsp_o.bitrev && $past(wr_req_i.mode) == BRAG_POST_INC);
  c_rd_wrap:   cover property (rd_rsp_o.modfix);
  c_ahb_read:  cover property (dph_rd_r ##1 hreadyout);

endmodule // brag_addr_gen

`default_nettype wire

// File: hdl/brag_rev_adder.sv
`timescale 1ns/1ns
`default_nettype none

// carries run from msb toward lsb; a carry out of bit 0 is dropped
module brag_rev_adder (
  input  wire logic [15:0] ptr,
  input  wire logic [15:0] modifier,
  output logic      [15:0] sum
);

  logic [15:0] ptr_rev;
  logic [15:0] mod_rev;
  logic [15:0] sum_rev;

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_rev
      assign ptr_rev[i] = ptr[15-i];
      assign mod_rev[i] = modifier[15-i];
      assign sum[i]     = sum_rev[15-i];
    end
  endgenerate

  assign sum_rev = ptr_rev + mod_rev;

endmodule // brag_rev_adder

`default_nettype wire

// File: inc/brag_pkg.sv
`default_nettype none

package brag_pkg;

  // register byte addresses on the bus
  localparam logic [31:0] BRAG_MODCTL_OFS  = 32'h0000_0000;
  localparam logic [31:0] BRAG_REVCTL_OFS  = 32'h0000_0004;
  localparam logic [31:0] BRAG_MODLO_OFS   = 32'h0000_0008;
  localparam logic [31:0] BRAG_MODHI_OFS   = 32'h0000_000C;
  localparam logic [31:0] BRAG_STATUS_OFS  = 32'h0000_0010;
  localparam logic [31:0] BRAG_ADDR_MASK   = 32'h0000_00FC;

  // modulo_control_reg fields
  localparam int          BRAG_WR_MOD_EN_BIT = 15;
  localparam int          BRAG_RD_MOD_EN_BIT = 14;
  localparam int          BRAG_RD_SEL_HI     = 11;
  localparam int          BRAG_RD_SEL_LO     = 8;
  localparam int          BRAG_WR_SEL_HI     = 7;
  localparam int          BRAG_WR_SEL_LO     = 4;
  localparam int          BRAG_REV_SEL_HI    = 3;
  localparam int          BRAG_REV_SEL_LO    = 0;

  // reversal_control_reg fields
  localparam int          BRAG_REV_EN_BIT    = 15;
  localparam int          BRAG_PIVOT_HI      = 14;
  localparam int          BRAG_PIVOT_LO      = 0;

  // status register fields
  localparam int          BRAG_STAT_BREV_BIT = 16;
  localparam int          BRAG_STAT_MOD_BIT  = 17;

  // reset values
  localparam logic [15:0] BRAG_MODCTL_RST    = 16'h0FFF;
  localparam logic [15:0] BRAG_REVCTL_RST    = 16'h0000;
  localparam logic [15:0] BRAG_MODLO_RST     = 16'h0000;
  localparam logic [15:0] BRAG_MODHI_RST     = 16'h0000;

  localparam logic [3:0]  BRAG_STACK_PTR     = 4'hF;
  localparam logic [15:0] BRAG_WORD_STEP     = 16'h0002;
  localparam logic [15:0] BRAG_BYTE_STEP     = 16'h0001;
  localparam logic [1:0]  BRAG_HTRANS_NSEQ   = 2'h2;

  typedef enum logic [2:0] {
    BRAG_DIRECT,
    BRAG_IND,
    BRAG_POST_INC,
    BRAG_POST_DEC,
    BRAG_PRE_INC,
    BRAG_PRE_DEC,
    BRAG_OFFSET
  } brag_mode_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  ptr_sel;
    logic [15:0] ptr_val;
    logic [15:0] offset;
    brag_mode_t  mode;
    logic        is_byte;
  } brag_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] ea;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_val;
    logic        bitrev;
    logic        modfix;
  } brag_rsp_t;

endpackage

`default_nettype wire

// File: tb/brag_addr_gen_bench.sv
`timescale 1ns/1ns
`default_nettype none

module brag_addr_gen_bench
  import brag_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        iss, iss_wr, iss_byte;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  iss_sel;
  brag_mode_t  iss_mode;
  brag_req_t   wr_req, rd_req;
  brag_rsp_t   wr_rsp, rd_rsp;
  int          bad_count, check_count;

  brag_addr_gen i_brag_addr_gen (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .wr_req_i(wr_req), .rd_req_i(rd_req), .wr_rsp_o(wr_rsp), .rd_rsp_o(rd_rsp)
  );

  brag_core_model i_brag_core_model (
    .hclk(hclk), .hresetn(hresetn), .iss(iss), .iss_wr(iss_wr), .iss_sel(iss_sel), .iss_mode(iss_mode),
    .iss_byte(iss_byte), .wr_rsp(wr_rsp), .rd_rsp(rd_rsp), .wr_req(wr_req), .rd_req(rd_req)
  );

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task chk_rsp(input brag_rsp_t g, input brag_rsp_t e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // bounded wait so a stuck slave cannot hang the run
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    if (hreadyout !== 1'h1) begin
      bad_count++;
      end_of_test();
    end
  endtask

  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= BRAG_HTRANS_NSEQ;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdv = hrdata;
  endtask

  // one request on one unit, answer judged in the cycle it stands
  task op(input logic wr, input logic [3:0] s, input brag_mode_t m, input logic b, input logic br,
          input logic mf, input logic [15:0] wv, input logic [15:0] ea);
    brag_rsp_t e;
    logic      nw;
    // these modes only address, the pointer is left alone
    nw = (m == BRAG_DIRECT) || (m == BRAG_IND) || (m == BRAG_OFFSET);
    e  = '{valid: 1'h1, ea: ea, wb_en: !nw, wb_sel: s, wb_val: wv, bitrev: br, modfix: mf};
    @(posedge hclk);
    iss      <= 1'h1;
    iss_wr   <= wr;
    iss_sel  <= s;
    iss_mode <= m;
    iss_byte <= b;
    @(posedge hclk);
    iss <= 1'h0;
    #1;
    chk_rsp(wr ? wr_rsp : rd_rsp, e);
  endtask

  task s_regs;
    ahb(1'h0, BRAG_MODCTL_OFS, 32'h0000_0000);
    chk(rdv, {16'h0000, BRAG_MODCTL_RST});
    chk({31'h0, hresp}, 32'h0000_0000);
    ahb(1'h0, BRAG_REVCTL_OFS, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    ahb(1'h0, 32'h0000_0040, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    ahb(1'h1, BRAG_REVCTL_OFS, 32'hFFFF_FFFF);
    ahb(1'h0, BRAG_REVCTL_OFS, 32'h0000_0000);
    chk(rdv, 32'h0000_FFFF);
  endtask

  task s_brev;
    ahb(1'h1, BRAG_MODCTL_OFS, 32'h0000_0002);
    ahb(1'h1, BRAG_REVCTL_OFS, 32'h0000_8008);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h1, 1'h0, 1'h0, 16'h1001, 16'h1000);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h1, 1'h0, 16'h1010, 16'h1000);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h1, 1'h0, 16'h1008, 16'h1010);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h1, 1'h0, 16'h1018, 16'h1008);
    op(1'h1, 4'h2, BRAG_PRE_INC, 1'h0, 1'h1, 1'h0, 16'h1004, 16'h1004);
    op(1'h1, 4'h2, BRAG_PRE_DEC, 1'h0, 1'h0, 1'h0, 16'h1002, 16'h1002);
    op(1'h0, 4'h2, BRAG_POST_INC, 1'h0, 1'h0, 1'h0, 16'h1004, 16'h1002);
    op(1'h1, 4'h3, BRAG_POST_INC, 1'h0, 1'h0, 1'h0, 16'h1002, 16'h1000);
  endtask

  task s_guard;
    ahb(1'h1, BRAG_MODCTL_OFS, 32'h0000_000F);
    op(1'h1, 4'hF, BRAG_POST_INC, 1'h0, 1'h0, 1'h0, 16'h1002, 16'h1000);
    ahb(1'h1, BRAG_MODCTL_OFS, 32'h0000_0002);
    ahb(1'h1, BRAG_REVCTL_OFS, 32'h0000_0008);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h0, 1'h0, 16'h1006, 16'h1004);
  endtask

  // both features on at once, on purpose, to see who wins
  task s_prio;
    ahb(1'h1, BRAG_MODLO_OFS, 32'h0000_1000);
    ahb(1'h1, BRAG_MODHI_OFS, 32'h0000_1003);
    ahb(1'h1, BRAG_MODCTL_OFS, 32'h0000_C322);
    ahb(1'h1, BRAG_REVCTL_OFS, 32'h0000_8008);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h1, 1'h0, 16'h1016, 16'h1006);
    op(1'h0, 4'h3, BRAG_POST_INC, 1'h0, 1'h0, 1'h1, 16'h1000, 16'h1002);
    ahb(1'h0, BRAG_STATUS_OFS, 32'h0000_0000);
    chk(rdv, 32'h0001_1006);
  endtask

  // other pivots, a long carry chain, and the non-updating modes
  task s_pivot;
    ahb(1'h1, BRAG_MODCTL_OFS, 32'h0000_0002);
    ahb(1'h1, BRAG_REVCTL_OFS, 32'h0000_8004);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h1, 1'h0, 16'h101E, 16'h1016);
    op(1'h1, 4'h2, BRAG_POST_INC, 1'h0, 1'h1, 1'h0, 16'h1010, 16'h101E);
    ahb(1'h1, BRAG_REVCTL_OFS, 32'h0000_8000);
    op(1'h1, 4'h2, BRAG_PRE_INC, 1'h0, 1'h1, 1'h0, 16'h1010, 16'h1010);
    op(1'h1, 4'h2, BRAG_IND, 1'h0, 1'h0, 1'h0, 16'h1010, 16'h1010);
    op(1'h1, 4'h2, BRAG_POST_DEC, 1'h0, 1'h0, 1'h0, 16'h100E, 16'h1010);
    op(1'h1, 4'h2, BRAG_OFFSET, 1'h0, 1'h0, 1'h0, 16'h100E, 16'h100E);
    op(1'h1, 4'h2, BRAG_DIRECT, 1'h0, 1'h0, 1'h0, 16'h100E, 16'h100E);
  endtask

  initial begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    hresetn     = 1'h0;
    hsel        = 1'h0;
    haddr       = '0;
    htrans      = 2'h0;
    hwrite      = 1'h0;
    hsize       = 3'h2;
    hwdata      = '0;
    iss         = 1'h0;
    iss_wr      = 1'h0;
    iss_sel     = 4'h0;
    iss_mode    = BRAG_DIRECT;
    iss_byte    = 1'h0;
    bad_count   = 0;
    check_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    s_regs();
    s_brev();
    s_guard();
    s_prio();
    s_pivot();
    end_of_test();
  end
endmodule // brag_addr_gen_bench

`default_nettype wire

// File: tb/brag_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// core side: owns the pointer file, updated only from the unit answers
module brag_core_model
  import brag_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       iss,
  input  wire logic       iss_wr,
  input  wire logic [3:0] iss_sel,
  input  wire brag_mode_t iss_mode,
  input  wire logic       iss_byte,
  input  wire brag_rsp_t  wr_rsp,
  input  wire brag_rsp_t  rd_rsp,
  output brag_req_t       wr_req,
  output brag_req_t       rd_req
);
  logic [15:0] ptr_r [16];
  brag_req_t   q;

  always_comb begin
    q = '{valid: iss, ptr_sel: iss_sel, ptr_val: ptr_r[iss_sel], offset: 16'h0000, mode: iss_mode,
          is_byte: iss_byte};
    wr_req = iss_wr ? q : '0;
    rd_req = iss_wr ? '0 : q;
  end

  // every buffer starts on a 32-byte boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 16; i++)
        ptr_r[i] <= 16'h1000;
    end else begin
      if (wr_rsp.valid && wr_rsp.wb_en)
        ptr_r[wr_rsp.wb_sel] <= wr_rsp.wb_val;
      if (rd_rsp.valid && rd_rsp.wb_en)
        ptr_r[rd_rsp.wb_sel] <= rd_rsp.wb_val;
    end
  end
endmodule // brag_core_model

`default_nettype wire
